// File: ltpc_defines.vh
// ltpc_defines.vh: constants for the laser and trigger path control block
// assumes inclusion by bare name from the design files
`ifndef LTPC_DEFINES_VH
`define LTPC_DEFINES_VH

`define LTPC_ADDR_W        4
// register indices (byte address = 4 * index is not used; plain port)
`define LTPC_REG_CTRL      4'h0
`define LTPC_REG_SWTRIG    4'h1
`define LTPC_REG_OFFDIST   4'h2
`define LTPC_REG_OFFDLY    4'h3
`define LTPC_REG_ENCRES    4'h4
`define LTPC_REG_STARTDLY  4'h5
`define LTPC_REG_EXTDIST   4'h6
`define LTPC_REG_CONSTSPD  4'h7
`define LTPC_REG_INCDIV    4'h8
`define LTPC_REG_OUTDIV    4'h9
`define LTPC_REG_STATUS    4'ha
`define LTPC_REG_DIST      4'hb
`define LTPC_REG_SYSINC    4'hc

// control register fields
`define LTPC_CTRL_LASER_EN   0
`define LTPC_CTRL_SRC_MODE   1
`define LTPC_CTRL_SRC_SEL    2
`define LTPC_CTRL_TIME_MODE  3
`define LTPC_CTRL_CONST_SPD  4
`define LTPC_CTRL_RESET      5'h00

// source select values
`define LTPC_SRC_DIN       1'b0
`define LTPC_SRC_SWTRIG    1'b1

// time base: 50 MHz clock, 1 us tick
`define LTPC_CLK_MHZ       50
`define LTPC_TICK_NS       1000
`define LTPC_TICK_CYC      ((`LTPC_TICK_NS * `LTPC_CLK_MHZ) / 1000)

// reset values of configuration
`define LTPC_OFFDIST_RST   32'h0000_0000
`define LTPC_ENCRES_RST    32'h0000_0001
`define LTPC_DIV_RST       16'h0001

`endif

// File: ltpc_divider.v
// ltpc_divider.v: pulse divider, one output pulse every div input pulses
// assumes div of zero is treated as one
`timescale 1ns/1ps

module ltpc_divider #(
  parameter W = 16
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // control
  input  wire [W-1:0] div,
  input  wire         in_pulse,
  // result
  output reg          out_pulse
);

  reg [W-1:0] cnt_q;

  always @(posedge clk) begin
    if (rst) begin
      cnt_q     <= {W{1'b0}};
      out_pulse <= 1'b0;
    end else begin
      out_pulse <= 1'b0;
      if (in_pulse) begin
        if (cnt_q + {{(W-1){1'b0}}, 1'b1} >= div) begin
          cnt_q     <= {W{1'b0}};
          out_pulse <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // ltpc_divider

// File: ltpc_top.v
// ltpc_top.v: laser switching, reading interval and system increment
// assumes inputs synchronous to CLK; encoder gives one-cycle pulses
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "ltpc_defines.vh"

module ltpc_top #(
  parameter DW = 32,
  parameter DIVW = 16
) (
  // clock and reset
  input  wire                   CLK,
  input  wire                   RST,
  // register port
  input  wire [`LTPC_ADDR_W-1:0] ADDR,
  input  wire [31:0]            WDATA,
  input  wire                   WR,
  input  wire                   RD,
  output reg  [31:0]            RDATA,
  // field signals
  input  wire                   TRIG_IN,
  input  wire                   ENC_PULSE,
  // outputs
  output reg                    LASER_ON,
  output reg                    MEAS_ACTIVE,
  output reg                    SYS_INC_OUT
);

  // configuration registers
  reg [4:0]      ctrl_q;
  reg [DW-1:0]   off_dist_q;
  reg [DW-1:0]   off_dly_q;
  reg [DW-1:0]   enc_res_q;
  reg [DW-1:0]   start_dly_q;
  reg [DW-1:0]   ext_dist_q;
  reg [DW-1:0]   const_spd_q;
  reg [DIVW-1:0] inc_div_q;
  reg [DIVW-1:0] out_div_q;
  reg            sw_trig_q;

  // working state
  reg            trig_prev_q;
  reg [DW-1:0]   dist_q;
  reg            acc_q;
  reg [DW-1:0]   stall_q;
  reg            las_q;
  reg [15:0]     tick_cnt_q;
  reg            tick_q;
  reg [DW-1:0]   iv_pos_q;
  reg            iv_run_q;
  reg            iv_trig_prev_q;
  reg            iv_end_q;
  reg [DW-1:0]   iv_end_pos_q;
  reg [DW-1:0]   sys_inc_cnt_q;

  wire laser_en   = ctrl_q[`LTPC_CTRL_LASER_EN];
  wire src_mode   = ctrl_q[`LTPC_CTRL_SRC_MODE];
  wire src_sel    = ctrl_q[`LTPC_CTRL_SRC_SEL];
  wire time_mode  = ctrl_q[`LTPC_CTRL_TIME_MODE];
  wire const_spd  = ctrl_q[`LTPC_CTRL_CONST_SPD];

  // trigger sources
  wire sw_trig_wr = WR && (ADDR == `LTPC_REG_SWTRIG);
  wire dig_trig   = TRIG_IN;
  wire interval_trig = dig_trig | sw_trig_q;
  wire laser_trig = src_mode ?
                    ((src_sel == `LTPC_SRC_SWTRIG) ? sw_trig_q : dig_trig)
                    : interval_trig;

  // distance step per cycle
  localparam [31:0] TICK_LAST = `LTPC_TICK_CYC - 1;
  wire tick_end = ({16'h0000, tick_cnt_q} == TICK_LAST);
  wire [DW-1:0] enc_step = ENC_PULSE ? enc_res_q : {DW{1'b0}};
  wire [DW-1:0] spd_step = tick_q ? const_spd_q : {DW{1'b0}};
  wire [DW-1:0] step = const_spd ? spd_step : enc_step;
  wire [DW-1:0] iv_step = time_mode ?
                          (tick_q ? {{(DW-1){1'b0}}, 1'b1} : {DW{1'b0}})
                          : step;

  wire trig_rise = laser_trig && !trig_prev_q;
  wire trig_fall = !laser_trig && trig_prev_q;
  // saturating sum so a long run never wraps the distance back to zero
  wire [DW:0]   dist_sum = {1'b0, dist_q} + {1'b0, step};
  wire [DW-1:0] dist_d   = dist_sum[DW] ? {DW{1'b1}} : dist_sum[DW-1:0];

  // interval arithmetic one or two bits wider so large settings never wrap
  wire [DW:0]   iv_pos_sum = {1'b0, iv_pos_q} + {1'b0, iv_step};
  wire [DW-1:0] iv_pos_d   = iv_pos_sum[DW] ? {DW{1'b1}}
                             : iv_pos_sum[DW-1:0];
  wire [DW+1:0] iv_end_sum = {2'b00, iv_pos_q} + {2'b00, start_dly_q}
                             + {2'b00, ext_dist_q};
  wire [DW-1:0] iv_end_d   = (iv_end_sum[DW+1:DW] != 2'b00) ?
                             {DW{1'b1}} : iv_end_sum[DW-1:0];
  wire [DW:0]   iv_lead    = {1'b0, iv_pos_q} + {1'b0, ext_dist_q};
  wire          iv_started = (iv_lead >= {1'b0, start_dly_q});

  // register writes
  always @(posedge CLK) begin
    if (RST) begin
      ctrl_q      <= `LTPC_CTRL_RESET;
      off_dist_q  <= `LTPC_OFFDIST_RST;
      off_dly_q   <= {DW{1'b0}};
      enc_res_q   <= `LTPC_ENCRES_RST;
      start_dly_q <= {DW{1'b0}};
      ext_dist_q  <= {DW{1'b0}};
      const_spd_q <= {DW{1'b0}};
      inc_div_q   <= `LTPC_DIV_RST;
      out_div_q   <= `LTPC_DIV_RST;
      sw_trig_q   <= 1'b0;
    end else begin
      if (sw_trig_wr)
        sw_trig_q <= WDATA[0];
      if (WR) begin
        case (ADDR)
          `LTPC_REG_CTRL:     ctrl_q      <= WDATA[4:0];
          `LTPC_REG_OFFDIST:  off_dist_q  <= WDATA[DW-1:0];
          `LTPC_REG_OFFDLY:   off_dly_q   <= WDATA[DW-1:0];
          `LTPC_REG_ENCRES:   enc_res_q   <= WDATA[DW-1:0];
          `LTPC_REG_STARTDLY: start_dly_q <= WDATA[DW-1:0];
          `LTPC_REG_EXTDIST:  ext_dist_q  <= WDATA[DW-1:0];
          `LTPC_REG_CONSTSPD: const_spd_q <= WDATA[DW-1:0];
          `LTPC_REG_INCDIV:   inc_div_q   <= WDATA[DIVW-1:0];
          `LTPC_REG_OUTDIV:   out_div_q   <= WDATA[DIVW-1:0];
          default: ;
        endcase
      end
    end
  end

  // microsecond tick for time-based counting
  always @(posedge CLK) begin
    if (RST) begin
      tick_cnt_q <= 16'h0000;
      tick_q     <= 1'b0;
    end else begin
      tick_q <= tick_end;
      if (tick_end)
        tick_cnt_q <= 16'h0000;
      else
        tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  // laser switch-off path
  always @(posedge CLK) begin
    if (RST) begin
      trig_prev_q <= 1'b0;
      dist_q      <= {DW{1'b0}};
      acc_q       <= 1'b0;
      stall_q     <= {DW{1'b0}};
      las_q       <= 1'b0;
    end else begin
      trig_prev_q <= laser_trig;
      if (laser_trig) begin
        las_q   <= 1'b1;
        acc_q   <= 1'b0;
        dist_q  <= {DW{1'b0}};
        stall_q <= {DW{1'b0}};
      end else if (trig_fall) begin
        acc_q   <= 1'b1;
        dist_q  <= {DW{1'b0}};
        stall_q <= {DW{1'b0}};
      end else if (acc_q) begin
        dist_q <= dist_d;
        if (dist_d >= off_dist_q) begin
          las_q <= 1'b0;
          acc_q <= 1'b0;
        end else if (step != {DW{1'b0}}) begin
          stall_q <= {DW{1'b0}};
        end else if (off_dly_q != {DW{1'b0}}) begin
          if (tick_q)
            stall_q <= stall_q + {{(DW-1){1'b0}}, 1'b1};
          if (stall_q >= off_dly_q) begin
            las_q <= 1'b0;
            acc_q <= 1'b0;
          end
        end
      end
    end
  end

  // reading interval: delay then extension before and after
  always @(posedge CLK) begin
    if (RST) begin
      iv_trig_prev_q <= 1'b0;
      iv_pos_q       <= {DW{1'b0}};
      iv_run_q       <= 1'b0;
      iv_end_q       <= 1'b0;
      iv_end_pos_q   <= {DW{1'b0}};
      MEAS_ACTIVE    <= 1'b0;
    end else begin
      iv_trig_prev_q <= interval_trig;
      if (interval_trig && !iv_trig_prev_q) begin
        iv_run_q <= 1'b1;
        iv_end_q <= 1'b0;
        iv_pos_q <= {DW{1'b0}};
      end else if (iv_run_q) begin
        iv_pos_q <= iv_pos_d;
        if (!interval_trig && iv_trig_prev_q) begin
          iv_end_q     <= 1'b1;
          iv_end_pos_q <= iv_end_d;
        end
        if (iv_end_q && iv_pos_q >= iv_end_pos_q) begin
          iv_run_q    <= 1'b0;
          MEAS_ACTIVE <= 1'b0;
        end else if (iv_started) begin
          MEAS_ACTIVE <= 1'b1;
        end
      end
    end
  end

  // system increment dividers
  wire inc_pulse;
  wire out_pulse;

  ltpc_divider #(.W(DIVW)) u_inc_div (
    .clk       (CLK),
    .rst       (RST),
    .div       (inc_div_q),
    .in_pulse  (ENC_PULSE),
    .out_pulse (inc_pulse)
  );

  ltpc_divider #(.W(DIVW)) u_out_div (
    .clk       (CLK),
    .rst       (RST),
    .div       (out_div_q),
    .in_pulse  (inc_pulse),
    .out_pulse (out_pulse)
  );

  always @(posedge CLK) begin
    if (RST) begin
      sys_inc_cnt_q <= {DW{1'b0}};
      SYS_INC_OUT   <= 1'b0;
    end else begin
      if (inc_pulse)
        sys_inc_cnt_q <= sys_inc_cnt_q + {{(DW-1){1'b0}}, 1'b1};
      SYS_INC_OUT <= out_pulse;
    end
  end

  // laser output
  always @(posedge CLK) begin
    if (RST)
      LASER_ON <= 1'b1;
    else if (!laser_en)
      LASER_ON <= 1'b1;
    else
      LASER_ON <= las_q | laser_trig;
  end

  // register reads, data in the cycle after the strobe
  always @(posedge CLK) begin
    if (RST) begin
      RDATA <= 32'h0000_0000;
    end else if (RD) begin
      case (ADDR)
        `LTPC_REG_CTRL:     RDATA <= {27'h0000000, ctrl_q};
        `LTPC_REG_SWTRIG:   RDATA <= {31'h00000000, sw_trig_q};
        `LTPC_REG_OFFDIST:  RDATA <= off_dist_q;
        `LTPC_REG_OFFDLY:   RDATA <= off_dly_q;
        `LTPC_REG_ENCRES:   RDATA <= enc_res_q;
        `LTPC_REG_STARTDLY: RDATA <= start_dly_q;
        `LTPC_REG_EXTDIST:  RDATA <= ext_dist_q;
        `LTPC_REG_CONSTSPD: RDATA <= const_spd_q;
        `LTPC_REG_INCDIV:   RDATA <= {16'h0000, inc_div_q};
        `LTPC_REG_OUTDIV:   RDATA <= {16'h0000, out_div_q};
        `LTPC_REG_STATUS:   RDATA <= {28'h0000000, MEAS_ACTIVE, acc_q,
                                      las_q, LASER_ON};
        `LTPC_REG_DIST:     RDATA <= dist_q;
        `LTPC_REG_SYSINC:   RDATA <= sys_inc_cnt_q;
        default:            RDATA <= 32'h0000_0000;
      endcase
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end

endmodule // ltpc_top

// File: ltpc_checker.sv
// ltpc_checker.sv: port assertions for the laser path block
// assumes binding onto ltpc_top, one clock, sync reset
`timescale 1ns/1ps
module ltpc_checker #(
  parameter DW   = 32,
  parameter DIVW = 16
) (
  // clock and reset
  input wire        CLK,
  input wire        RST,
  // register port
  input wire [3:0]  ADDR,
  input wire [31:0] WDATA,
  input wire        WR,
  input wire        RD,
  input wire [31:0] RDATA,
  // field lines and outputs
  input wire        TRIG_IN,
  input wire        ENC_PULSE,
  input wire        LASER_ON,
  input wire        MEAS_ACTIVE,
  input wire        SYS_INC_OUT
);
  reg  [4:0] ctl_q;
  reg        dly_q;
  reg        seen_q;
  wire       en = ctl_q[0] & ~ctl_q[2];
  always @(posedge CLK) begin
    if (RST) begin
      ctl_q  <= 5'h00;
      dly_q  <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      if (WR && ADDR == 4'h0) ctl_q <= WDATA[4:0];
      if (WR && ADDR == 4'h3) dly_q <= |WDATA;
      if (TRIG_IN) seen_q <= 1'b1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  chk_reset_vals: assert property (disable iff (1'b0)
    RST |=> LASER_ON && !MEAS_ACTIVE && !SYS_INC_OUT)
    else $error("outputs wrong after reset");
  chk_ctl_off_on: assert property (
    !ctl_q[0] && !$past(ctl_q[0]) |-> LASER_ON)
    else $error("laser off with control disabled");
  chk_trig_on: assert property (
    en && $past(en) && TRIG_IN |-> ##[1:2] LASER_ON)
    else $error("trigger did not switch laser on");
  chk_trig_hold: assert property (
    en && $past(en) && TRIG_IN && LASER_ON |=> LASER_ON)
    else $error("laser dropped during trigger");
  chk_idle_off: assert property (
    en && $past(en, 2) && !seen_q |-> !LASER_ON)
    else $error("laser on with no object");
  chk_laser_cause: assert property (
    en && $past(en) && $rose(LASER_ON) |->
    $past(TRIG_IN) || $past(TRIG_IN, 2))
    else $error("laser rose without trigger");
  chk_off_enc: assert property (
    en && $past(en, 2) && !ctl_q[4] && !dly_q && $fell(LASER_ON) |->
    $past(ENC_PULSE) || $past(ENC_PULSE, 2) || $past(ENC_PULSE, 3))
    else $error("laser fell without encoder step");
  chk_inc_cause: assert property (
    SYS_INC_OUT |-> $past(ENC_PULSE, 3))
    else $error("increment without encoder pulse");
  cover property (TRIG_IN && !LASER_ON);
  cover property ($fell(LASER_ON));
  cover property (SYS_INC_OUT);
  cover property ($rose(MEAS_ACTIVE));
endmodule // ltpc_checker

bind ltpc_top ltpc_checker #(.DW(DW), .DIVW(DIVW)) u_ltpc_checker (
  .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .TRIG_IN(TRIG_IN), .ENC_PULSE(ENC_PULSE),
  .LASER_ON(LASER_ON), .MEAS_ACTIVE(MEAS_ACTIVE),
  .SYS_INC_OUT(SYS_INC_OUT));

// File: ltpc_field_model.sv
// ltpc_field_model.sv: photoelectric sensor and conveyor encoder
// assumes obj and run change just after a rising edge
`timescale 1ns/1ps
module ltpc_field_model #(
  parameter PER = 4
) (
  // clock
  input  wire clk,
  // scene
  input  wire obj,
  input  wire run,
  // field lines
  output reg  trig,
  output reg  enc
);
  reg [7:0] cnt_q = 8'h00;
  initial begin
    trig = 1'b0;
    enc  = 1'b0;
  end
  always @(posedge clk) begin
    trig  <= obj;
    enc   <= run && cnt_q == 8'h00;
    cnt_q <= (cnt_q == 8'h00) ? 8'(PER - 1) : cnt_q - 8'h01;
  end
endmodule // ltpc_field_model

// File: testbench.sv
// testbench.sv: register tasks and laser, distance and increment tests
// assumes ltpc_top with the field model on its trigger and encoder
`timescale 1ns/1ps
module testbench;
  reg         CLK, RST, WR, RD, obj, run;
  reg  [3:0]  ADDR;
  reg  [31:0] WDATA;
  wire [31:0] RDATA;
  wire        TRIG_IN, ENC_PULSE, LASER_ON, MEAS_ACTIVE, SYS_INC_OUT;
  integer     n_mismatch = 0;
  integer     checks_done = 0;
  integer     inc_n = 0;
  ltpc_top u_ltpc_top (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .TRIG_IN(TRIG_IN), .ENC_PULSE(ENC_PULSE),
    .LASER_ON(LASER_ON), .MEAS_ACTIVE(MEAS_ACTIVE),
    .SYS_INC_OUT(SYS_INC_OUT));
  ltpc_field_model u_ltpc_field_model (
    .clk(CLK), .obj(obj), .run(run), .trig(TRIG_IN), .enc(ENC_PULSE));
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  always @(posedge CLK)
    if (SYS_INC_OUT === 1'b1) inc_n = inc_n + 1;
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge CLK);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    begin
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK);
      WR    <= 1'b0;
      #1;
    end
  endtask
  task rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    begin
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLK);
      RD   <= 1'b0;
      #1 cmp(nm, e, RDATA);
    end
  endtask
  task pulses(input integer n);
    integer c, t;
    begin
      c = 0;
      for (t = 0; t < 4000 && c < n; t = t + 1) begin
        @(posedge CLK);
        if (ENC_PULSE === 1'b1) c = c + 1;
      end
      if (c < n) begin
        n_mismatch = n_mismatch + 1;
        end_sim;
      end
    end
  endtask
  task obj_pass;
    begin
      obj <= 1'b1;
      cyc(3);
      obj <= 1'b0;
      cyc(2);
    end
  endtask
  task incs(input logic [15:0] i, input logic [15:0] o,
            input integer n, input integer e);
    integer b;
    begin
      wr(4'h8, {16'h0000, i});
      wr(4'h9, {16'h0000, o});
      b = inc_n;
      run <= 1'b1;
      pulses(n);
      run <= 1'b0;
      cyc(4);
      cmp("sys inc", e, inc_n - b);
    end
  endtask
  initial begin
    RST   = 1'b1;
    WR    = 1'b0;
    RD    = 1'b0;
    obj   = 1'b0;
    run   = 1'b0;
    ADDR  = 4'h0;
    WDATA = 32'h0000_0000;
    cyc(3);
    RST <= 1'b0;
    #1 cmp("reset laser", 1, LASER_ON);
    rdc(4'h4, 32'h0000_0001, "encres");
    rdc(4'h8, 32'h0000_0001, "incdiv");
    wr(4'hd, 32'hffff_ffff);
    rdc(4'hd, 32'h0000_0000, "unmapped");
    wr(4'h2, 32'h0000_000a);
    wr(4'h0, 32'h0000_0001);
    rdc(4'h0, 32'h0000_0001, "ctrl");
    cyc(3);
    #1 cmp("idle", 0, LASER_ON);
    obj <= 1'b1;
    cyc(3);
    #1 cmp("trig on", 1, LASER_ON);
    obj <= 1'b0;
    cyc(2);
    run <= 1'b1;
    pulses(9);
    cyc(2);
    #1 cmp("before off", 1, LASER_ON);
    pulses(1);
    cyc(3);
    #1 cmp("dist off", 0, LASER_ON);
    rdc(4'hb, 32'h0000_000a, "dist");
    obj_pass;
    pulses(6);
    obj_pass;
    pulses(6);
    cyc(2);
    #1 cmp("restart", 1, LASER_ON);
    pulses(4);
    cyc(3);
    #1 cmp("restart off", 0, LASER_ON);
    run <= 1'b0;
    wr(4'h3, 32'h0000_0005);
    obj_pass;
    cyc(150);
    #1 cmp("stall on", 1, LASER_ON);
    cyc(200);
    #1 cmp("stall off", 0, LASER_ON);
    wr(4'h3, 32'h0000_0000);
    wr(4'h7, 32'h0000_0001);
    wr(4'h2, 32'h0000_0004);
    wr(4'h0, 32'h0000_0011);
    obj_pass;
    cyc(100);
    #1 cmp("speed on", 1, LASER_ON);
    cyc(250);
    #1 cmp("speed off", 0, LASER_ON);
    wr(4'h0, 32'h0000_0001);
    incs(16'h0002, 16'h0003, 24, 4);
    incs(16'h0003, 16'h0001, 9, 3);
    wr(4'h5, 32'h0000_0008);
    wr(4'h6, 32'h0000_0002);
    obj <= 1'b1;
    cyc(3);
    #1 cmp("meas idle", 0, MEAS_ACTIVE);
    run <= 1'b1;
    pulses(5);
    cyc(2);
    #1 cmp("meas early", 0, MEAS_ACTIVE);
    pulses(1);
    cyc(2);
    #1 cmp("meas start", 1, MEAS_ACTIVE);
    run <= 1'b0;
    obj <= 1'b0;
    cyc(3);
    #1 cmp("meas hold", 1, MEAS_ACTIVE);
    run <= 1'b1;
    pulses(9);
    cyc(2);
    #1 cmp("meas tail", 1, MEAS_ACTIVE);
    pulses(1);
    cyc(2);
    #1 cmp("meas end", 0, MEAS_ACTIVE);
    run <= 1'b0;
    wr(4'h0, 32'h0000_0009);
    obj <= 1'b1;
    cyc(200);
    #1 cmp("time early", 0, MEAS_ACTIVE);
    cyc(200);
    #1 cmp("time start", 1, MEAS_ACTIVE);
    obj <= 1'b0;
    cyc(400);
    #1 cmp("time hold", 1, MEAS_ACTIVE);
    cyc(300);
    #1 cmp("time end", 0, MEAS_ACTIVE);
    run <= 1'b1;
    pulses(4);
    run <= 1'b0;
    wr(4'h0, 32'h0000_0007);
    cyc(3);
    #1 cmp("sw idle", 0, LASER_ON);
    wr(4'h1, 32'h0000_0001);
    cyc(3);
    #1 cmp("sw trig", 1, LASER_ON);
    wr(4'h1, 32'h0000_0000);
    run <= 1'b1;
    pulses(4);
    run <= 1'b0;
    cyc(3);
    #1 cmp("sw off", 0, LASER_ON);
    wr(4'h0, 32'h0000_0000);
    cyc(3);
    #1 cmp("ctl off", 1, LASER_ON);
    end_sim;
  end
endmodule // testbench
